// File: logic/fctu_top.sv
// Flow-control target unit: branch, jump and trap target computation
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "fctu_params.svh"
// Function
// - Targets use signed add, truncated, no overflow
// - Register jump takes source two, low bits cleared
// - Register jump ignores first source and destination
// - Register bound trap when source one above two
// - Bound trap address: base, bound vector, zeros
// - Bit tests examine selected bit, set or clear
// - Taken test trap fetches base, vector, zeros
// - Trap vector number is low nine bits
// - Mask bits 24..21 pick sign/zero combinations
// - Mask bit 25 ignored by evaluation
// - Named condition patterns evaluate correctly
// - Sign is bit 31, zero NORs 30..0
// - Conditional branch adds scaled short offset
// - Low sixteen bits are signed branch offset
// - Immediate bound trap when source above immediate
// - Unconditional branch adds scaled long offset
module fctu_top
(
    input  wire logic               clk,               // Processor clock
    input  wire logic               resetn,            // Synchronous reset, active low
    input  wire logic               instr_valid,       // Decoded instruction present
    input  wire fctu_pkg::fctu_op_t instr_op,          // Operation class
    input  wire logic               instr_delayed,     // Delayed variant
    input  wire logic [31:0]        instr_word,        // Raw instruction word
    input  wire logic [31:0]        first_source_reg,  // First source value
    input  wire logic [31:0]        second_source_reg, // Second source value
    input  wire logic [31:0]        execute_pointer,   // Address of this instruction
    input  wire logic [19:0]        vector_base,       // Vector base page
    input  wire logic [3:0]         reg_addr,          // Register byte address
    input  wire logic [31:0]        reg_wdata,         // Register write data
    input  wire logic               reg_wr,            // Write strobe
    input  wire logic               reg_rd,            // Read strobe
    output logic      [31:0]        reg_rdata,         // Read data, one cycle after read
    output logic                    fetch_load,        // Load fetch pointer, pulse
    output logic      [31:0]        fetch_pointer,     // New fetch address
    output logic                    trap_req,          // Exception request, pulse
    output logic      [8:0]         trap_vector,       // Vector number of the trap
    output logic                    squash_next,       // Drop following instruction
    output logic                    irq                // Level interrupt
);

    // Evaluate a condition mask against a tested register
    function automatic logic cond_true(input logic [4:0] mask, input logic [31:0] v);
        logic s;
        logic z;
        s = v[31];
        z = ~|v[30:0];
        // Bit 4 of the mask (word bit 25) is never looked at
        cond_true = (mask[3] & s & z) | (mask[2] & s & ~z)
                  | (mask[1] & ~s & z) | (mask[0] & ~s & ~z);
    endfunction : cond_true

    // Form a trap fetch address from base page and vector number
    function automatic logic [31:0] vec_addr(input logic [19:0] base, input logic [8:0] vec);
        vec_addr = {base, vec, 3'h0};
    endfunction : vec_addr

    // Registers and next values
    logic        enable_q;                 // Unit enable, software controlled
    logic [2:0]  status_q;                 // Sticky event bits
    logic [2:0]  status_d;                 // Next status
    logic [2:0]  mask_q;                   // Interrupt mask
    logic [31:0] rdata_q;                  // Read data register
    logic        load_q;                   // Fetch load pulse
    logic [31:0] target_q;                 // Fetch pointer result
    logic        trap_q;                   // Trap request pulse
    logic [8:0]  vec_q;                    // Trap vector number
    logic        squash_q;                 // Squash pulse
    logic        irq_q;                    // Interrupt level

    // Decoded fields
    logic [4:0]  sel_field;                // Bit select or condition mask field
    logic [15:0] short_branch_offset;      // Short signed offset
    logic [25:0] long_branch_offset;       // Long signed offset
    logic [15:0] bound_immediate;          // Unsigned bound
    logic [8:0]  vector_number_field;      // Trap vector index
    logic        sel_bit;                  // Selected bit of first source
    logic [31:0] short_target;             // Execute pointer plus short offset
    logic [31:0] long_target;              // Execute pointer plus long offset

    // Combinational decision
    logic        go;                       // Instruction accepted
    logic        take_load;                // Fetch pointer changes
    logic        take_trap;                // Trap raised
    logic        take_bound;               // Trap is a bound-check
    logic [31:0] next_target;              // Target for this instruction
    logic [8:0]  next_vec;                 // Vector for this instruction

    // Field extraction
    assign sel_field           = instr_word[`FCTU_SEL_HI:`FCTU_SEL_LO];
    assign short_branch_offset = instr_word[`FCTU_SHORT_HI:0];
    assign long_branch_offset  = instr_word[`FCTU_LONG_HI:0];
    assign bound_immediate     = instr_word[`FCTU_SHORT_HI:0];
    assign vector_number_field = instr_word[`FCTU_VEC_HI:0];
    assign sel_bit             = first_source_reg[sel_field];

    // Scaled, sign-extended offsets added with wrap-around
    assign short_target = execute_pointer
                        + {{14{short_branch_offset[15]}}, short_branch_offset, 2'h0};
    assign long_target  = execute_pointer
                        + {{4{long_branch_offset[25]}}, long_branch_offset, 2'h0};

    // An instruction counts only while the unit is enabled
    assign go = instr_valid & enable_q;

    // Operation decision
    always_comb
    begin
        take_load   = 1'b0;
        take_trap   = 1'b0;
        take_bound  = 1'b0;
        next_target = 32'h0000_0000;
        next_vec    = 9'h000;
        case (instr_op)
            fctu_pkg::FCTU_OP_JUMP_REG:
            begin
                // Only source two matters here
                take_load   = 1'b1;
                next_target = {second_source_reg[31:2], 2'h0};
            end
            fctu_pkg::FCTU_OP_BND_REG:
            begin
                take_bound = first_source_reg > second_source_reg;
                next_vec   = `FCTU_BOUND_VEC;
            end
            fctu_pkg::FCTU_OP_BND_IMM:
            begin
                take_bound = first_source_reg > {16'h0000, bound_immediate};
                next_vec   = `FCTU_BOUND_VEC;
            end
            fctu_pkg::FCTU_OP_TRAP_CLR:
            begin
                take_trap = ~sel_bit;
                next_vec  = vector_number_field;
            end
            fctu_pkg::FCTU_OP_TRAP_SET:
            begin
                take_trap = sel_bit;
                next_vec  = vector_number_field;
            end
            fctu_pkg::FCTU_OP_TRAP_CND:
            begin
                take_trap = cond_true(sel_field, first_source_reg);
                next_vec  = vector_number_field;
            end
            fctu_pkg::FCTU_OP_BR_CLR:
            begin
                take_load   = ~sel_bit;
                next_target = short_target;
            end
            fctu_pkg::FCTU_OP_BR_SET:
            begin
                take_load   = sel_bit;
                next_target = short_target;
            end
            fctu_pkg::FCTU_OP_BR_CND:
            begin
                take_load   = cond_true(sel_field, first_source_reg);
                next_target = short_target;
            end
            fctu_pkg::FCTU_OP_JUMP_REL:
            begin
                take_load   = 1'b1;
                next_target = long_target;
            end
            default:
            begin
                take_load = 1'b0;
            end
        endcase
        // Bound traps vector through the same base page
        if (take_bound)
        begin
            take_trap = 1'b1;
        end
        if (take_trap)
        begin
            take_load   = 1'b1;
            next_target = vec_addr(vector_base, next_vec);
        end
    end

    // Fetch redirect outputs
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            load_q   <= 1'b0;
            target_q <= 32'h0000_0000;
            trap_q   <= 1'b0;
            vec_q    <= 9'h000;
            squash_q <= 1'b0;
        end
        else
        begin
            load_q   <= go & take_load;
            trap_q   <= go & take_trap;
            // Delay slot survives only for delayed variants
            squash_q <= go & take_load & ~instr_delayed;
            if (go & take_load)
            begin
                target_q <= next_target;
                vec_q    <= next_vec;
            end
        end
    end

    // Status next value: events win over a read clear
    always_comb
    begin
        status_d = status_q;
        if (reg_rd && reg_addr == `FCTU_STATUS_OFS)
        begin
            status_d = 3'h0;
        end
        // Clear first, then let this cycle's events set their bits
        status_d[`FCTU_EV_BRANCH] = status_d[`FCTU_EV_BRANCH] | (go & take_load & ~take_trap);
        status_d[`FCTU_EV_TRAP]   = status_d[`FCTU_EV_TRAP] | (go & take_trap & ~take_bound);
        status_d[`FCTU_EV_BOUND]  = status_d[`FCTU_EV_BOUND] | (go & take_bound);
    end

    // Status register
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            status_q <= 3'h0;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    // Software writes to control and mask
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            enable_q <= `FCTU_CTRL_RST;
            mask_q   <= `FCTU_MASK_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `FCTU_CTRL_OFS)
            begin
                enable_q <= reg_wdata[0];
            end
            else if (reg_addr == `FCTU_MASK_OFS)
            begin
                mask_q <= reg_wdata[2:0];
            end
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (!reg_rd)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (reg_addr == `FCTU_CTRL_OFS)
        begin
            rdata_q <= {31'h0000_0000, enable_q};
        end
        else if (reg_addr == `FCTU_STATUS_OFS)
        begin
            rdata_q <= {29'h0000_0000, status_q};
        end
        else if (reg_addr == `FCTU_MASK_OFS)
        begin
            rdata_q <= {29'h0000_0000, mask_q};
        end
        else if (reg_addr == `FCTU_TARGET_OFS)
        begin
            rdata_q <= target_q;
        end
        else
        begin
            // Unmapped addresses read zero
            rdata_q <= 32'h0000_0000;
        end
    end

    // Interrupt level from next status and mask
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(status_d & mask_q);
        end
    end

    // Every output comes straight from a flip-flop
    assign reg_rdata     = rdata_q;
    assign fetch_load    = load_q;
    assign fetch_pointer = target_q;
    assign trap_req      = trap_q;
    assign trap_vector   = vec_q;
    assign squash_next   = squash_q;
    assign irq           = irq_q;

    // Checks on the computed targets and traps
    sequence s_accept(fctu_pkg::fctu_op_t op);
        resetn && instr_valid && enable_q && instr_op == op;
    endsequence

    a_jump_target: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_JUMP_REG) |=> fetch_load && !trap_req
            && fetch_pointer == ($past(second_source_reg) & 32'hFFFF_FFFC))
        else $error("register jump target wrong");

    a_bound_reg_trap: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_BND_REG) |=> trap_req
            == ($past(first_source_reg) > $past(second_source_reg)))
        else $error("register bound compare wrong");

    a_bound_addr: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_BND_IMM) ##1 trap_req |->
            fetch_pointer == {$past(vector_base), `FCTU_BOUND_VEC, 3'h0})
        else $error("bound trap address wrong");

    a_bound_imm_trap: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_BND_IMM) |=> trap_req
            == ($past(first_source_reg) > {16'h0000, $past(instr_word[15:0])}))
        else $error("immediate bound compare wrong");

    a_bit_trap: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_TRAP_SET) |=> trap_req
            == $past(first_source_reg[instr_word[25:21]]))
        else $error("bit-set trap decision wrong");

    a_trap_vector: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_TRAP_CND) ##1 trap_req |->
            fetch_pointer == {$past(vector_base), $past(instr_word[8:0]), 3'h0}
            && trap_vector == $past(instr_word[8:0]))
        else $error("condition trap vector wrong");

    a_cond_ignore25: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_BR_CND) ##0 (instr_word[24:21] == 4'h0) |=> !fetch_load)
        else $error("reserved mask bit changed outcome");

    a_short_branch: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_BR_SET) ##1 fetch_load |->
            fetch_pointer == $past(execute_pointer)
            + {{14{$past(instr_word[15])}}, $past(instr_word[15:0]), 2'h0})
        else $error("short branch target wrong");

    a_long_branch: assert property (@(posedge clk) disable iff (!resetn)
        s_accept(fctu_pkg::FCTU_OP_JUMP_REL) |=> fetch_load && fetch_pointer
            == $past(execute_pointer) + {{4{$past(instr_word[25])}}, $past(instr_word[25:0]), 2'h0})
        else $error("long branch target wrong");

    a_squash_next: assert property (@(posedge clk) disable iff (!resetn)
        fetch_load |-> squash_next == !$past(instr_delayed))
        else $error("delay slot handling wrong");

endmodule : fctu_top

// File: logic/fctu_params.svh
// Constants for the flow-control target unit: register map, fields, reset values
`ifndef FCTU_PARAMS_SVH
`define FCTU_PARAMS_SVH

// Register offsets on the plain register port
`define FCTU_CTRL_OFS       4'h0
`define FCTU_STATUS_OFS     4'h4
`define FCTU_MASK_OFS       4'h8
`define FCTU_TARGET_OFS     4'hC

// Reset values
`define FCTU_CTRL_RST       1'h1
`define FCTU_MASK_RST       3'h0

// Status and mask bit positions
`define FCTU_EV_BRANCH      0
`define FCTU_EV_TRAP        1
`define FCTU_EV_BOUND       2

// Vector number used by a bound-check trap (plain default)
`define FCTU_BOUND_VEC      9'h005

// Instruction word field positions
`define FCTU_SEL_HI         25
`define FCTU_SEL_LO         21
`define FCTU_VEC_HI         8
`define FCTU_SHORT_HI       15
`define FCTU_LONG_HI        25

`endif

// File: logic/fctu_pkg.sv
// Types shared by the flow-control target unit
package fctu_pkg;

    // Flow-control operation class delivered by the decoder
    typedef enum logic [3:0] {
        FCTU_OP_NONE     = 4'h0,
        FCTU_OP_JUMP_REG = 4'h1,
        FCTU_OP_BND_REG  = 4'h2,
        FCTU_OP_BND_IMM  = 4'h3,
        FCTU_OP_TRAP_CLR = 4'h4,
        FCTU_OP_TRAP_SET = 4'h5,
        FCTU_OP_TRAP_CND = 4'h6,
        FCTU_OP_BR_CLR   = 4'h7,
        FCTU_OP_BR_SET   = 4'h8,
        FCTU_OP_BR_CND   = 4'h9,
        FCTU_OP_JUMP_REL = 4'hA
    } fctu_op_t;

endpackage : fctu_pkg

// File: test/fctu_fetch_model.sv
// Fetch-side model: follows each new fetch address and counts loads
`timescale 1ns/1ps
module fctu_fetch_model
(
    input  wire logic        clk,           // Processor clock
    input  wire logic        resetn,        // Synchronous reset, active low
    input  wire logic        fetch_load,    // Load pulse from the unit
    input  wire logic [31:0] fetch_pointer, // New fetch address
    input  wire logic        trap_req,      // Exception request
    output logic      [15:0] load_count,    // Loads taken so far
    output logic      [15:0] trap_count     // Exception entries so far
);
    logic [31:0] fetch_q; // Current fetch address of the sequencer
    // Reload on each pulse, else step one word
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            fetch_q    <= 32'h0000_0000;
            load_count <= 16'h0000;
            trap_count <= 16'h0000;
        end
        else if (fetch_load)
        begin
            fetch_q    <= fetch_pointer;
            load_count <= load_count + 16'h0001;
            trap_count <= trap_count + {15'h0000, trap_req};
        end
        else
            fetch_q <= fetch_q + 32'h0000_0004;
    end
endmodule : fctu_fetch_model

// File: test/testbench.sv
// Self-checking bench for the flow-control target unit
`timescale 1ns/1ps
`include "fctu_params.svh"
module testbench;
    logic               clk;        // Processor clock
    logic               resetn;     // Reset, active low
    logic               ivalid;     // Instruction present
    fctu_pkg::fctu_op_t iop;        // Operation class
    logic               idly;       // Delayed variant
    logic [31:0]        iword;      // Instruction word
    logic [31:0]        src_a;      // First source value
    logic [31:0]        src_b;      // Second source value
    logic [31:0]        exec_ptr;   // Address of the instruction
    logic [19:0]        vec_base;   // Vector base page
    logic [3:0]         reg_addr;   // Register address
    logic [31:0]        reg_wdata;  // Register write data
    logic               reg_wr;     // Write strobe
    logic               reg_rd;     // Read strobe
    logic [31:0]        reg_rdata;  // Read data
    logic               fload;      // Load pulse
    logic [31:0]        fptr;       // Target address
    logic               trap_req;   // Exception pulse
    logic [8:0]         tvec;       // Trap vector number
    logic               squash;     // Squash pulse
    logic               irq;        // Interrupt level
    logic [15:0]        load_count; // Loads seen by the model
    logic [15:0]        trap_count; // Exception entries seen by the model
    int                 n_errors;   // Mismatches
    int                 checked;    // Comparisons
    int                 n_loads;    // Loads expected
    int                 n_traps;    // Exception entries expected
    fctu_top u_fctu_top (.clk(clk), .resetn(resetn), .instr_valid(ivalid), .instr_op(iop),
        .instr_delayed(idly), .instr_word(iword), .first_source_reg(src_a),
        .second_source_reg(src_b), .execute_pointer(exec_ptr), .vector_base(vec_base),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fetch_load(fload), .fetch_pointer(fptr),
        .trap_req(trap_req), .trap_vector(tvec), .squash_next(squash), .irq(irq));
    fctu_fetch_model u_fctu_fetch_model (.clk(clk), .resetn(resetn), .fetch_load(fload),
        .fetch_pointer(fptr), .trap_req(trap_req), .load_count(load_count),
        .trap_count(trap_count));
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    // Compare one value, report and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // One register write cycle
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // One register read cycle, data judged in the following cycle
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : reg_read
    // Interrupt level one cycle on
    task automatic irq_chk(input logic exp);
        @(posedge clk);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_chk
    // Issue one instruction and judge the answer one cycle later
    task automatic issue(input fctu_pkg::fctu_op_t op, input logic [31:0] w,
        input logic [31:0] a, input logic [31:0] b, input logic dly, input logic take,
        input logic trap, input logic [31:0] ptr, input logic [8:0] vec);
        @(posedge clk);
        ivalid <= 1'b1;
        iop    <= op;
        iword  <= w;
        src_a  <= a;
        src_b  <= b;
        idly   <= dly;
        @(posedge clk);
        ivalid <= 1'b0;
        #1;
        n_loads += int'(take);
        n_traps += int'(take & trap);
        chk("fetch_load", {31'h0, take}, {31'h0, fload});
        chk("trap_req", {31'h0, take & trap}, {31'h0, trap_req});
        chk("squash_next", {31'h0, take & ~dly}, {31'h0, squash});
        if (take)
        begin
            chk("fetch_pointer", ptr, fptr);
            chk("trap_vector", {23'h0, vec}, {23'h0, tvec});
        end
    endtask : issue
    // Named condition judged as a signed compare; mask bit 4 is never looked at
    function automatic logic cnd(input logic [4:0] m, input logic [31:0] r);
        case (m[3:0])
            4'h2: return r == 32'h0;
            4'hD: return r != 32'h0;
            4'h1: return $signed(r) > 0;
            4'hC: return $signed(r) < 0;
            4'h3: return $signed(r) >= 0;
            4'hE: return $signed(r) <= 0;
            default: return 1'b0;
        endcase
    endfunction : cnd
    // Vectored trap address
    function automatic logic [31:0] tadr(input logic [8:0] v);
        return {vec_base, v, 3'h0};
    endfunction : tadr
    // Short-offset branch target
    function automatic logic [31:0] sadr(input logic [31:0] w);
        return exec_ptr + {{14{w[15]}}, w[15:0], 2'h0};
    endfunction : sadr
    // Reset values of registers and outputs
    task automatic t_reset();
        #1;
        chk("fetch_load", 32'h0, {31'h0, fload});
        reg_read(4'h0, 32'h0000_0001, "ctrl");
        reg_read(4'h8, 32'h0000_0000, "mask");
        reg_read(4'h4, 32'h0000_0000, "status");
        $display("test reset done");
    endtask : t_reset
    // Register jump and both bound checks
    task automatic t_jump_bound();
        issue(fctu_pkg::FCTU_OP_JUMP_REG, 32'h03FF_0000, 32'h1234_5678, 32'hDEAD_BEEF,
            1'b0, 1'b1, 1'b0, 32'hDEAD_BEEC, 9'h000);
        issue(fctu_pkg::FCTU_OP_JUMP_REG, 32'h0000_0000, 32'hFFFF_FFFF, 32'hDEAD_BEEF,
            1'b1, 1'b1, 1'b0, 32'hDEAD_BEEC, 9'h000);
        issue(fctu_pkg::FCTU_OP_BND_REG, 32'h03E0_0000, 32'h8000_0000, 32'h7FFF_FFFF,
            1'b0, 1'b1, 1'b1, tadr(`FCTU_BOUND_VEC), `FCTU_BOUND_VEC);
        issue(fctu_pkg::FCTU_OP_BND_REG, 32'h0000_0000, 32'h7FFF_FFFF, 32'h7FFF_FFFF,
            1'b0, 1'b0, 1'b0, 32'h0, 9'h000);
        issue(fctu_pkg::FCTU_OP_BND_IMM, 32'h0000_8000, 32'h0000_8001, 32'h0,
            1'b0, 1'b1, 1'b1, tadr(`FCTU_BOUND_VEC), `FCTU_BOUND_VEC);
        issue(fctu_pkg::FCTU_OP_BND_IMM, 32'h0000_8000, 32'h0000_8000, 32'hFFFF_FFFF,
            1'b0, 1'b0, 1'b0, 32'h0, 9'h000);
        $display("test jump and bound done");
    endtask : t_jump_bound
    // Bit tests: traps and branches on bits 0, 13 and 31
    task automatic t_bits();
        logic [31:0] w;
        logic [31:0] r;
        logic        bit_v;
        for (int k = 0; k < 12; k++)
        begin
            w = {6'h00, 5'((k % 3) * 13 + (k % 3) / 2 * 5), 5'h00, 16'h7FFF};
            r = (k < 6) ? 32'h8000_0021 : 32'h7FFF_FFDE;
            bit_v = r[w[25:21]];
            issue(fctu_pkg::FCTU_OP_TRAP_CLR, w, r, 32'h0, 1'b0, ~bit_v, 1'b1,
                tadr(w[8:0]), w[8:0]);
            issue(fctu_pkg::FCTU_OP_TRAP_SET, w, r, 32'h0, 1'b0, bit_v, 1'b1,
                tadr(w[8:0]), w[8:0]);
            issue(fctu_pkg::FCTU_OP_BR_CLR, w, r, 32'h0, k[0], ~bit_v, 1'b0,
                sadr(w), 9'h000);
            issue(fctu_pkg::FCTU_OP_BR_SET, w, r, 32'h0, k[0], bit_v, 1'b0,
                sadr(w), 9'h000);
        end
        $display("test bit tests done");
    endtask : t_bits
    // Named conditions and reserved mask bit over all sign and zero cases
    task automatic t_cond();
        logic [4:0]  masks [8] = '{5'h02, 5'h0D, 5'h01, 5'h0C, 5'h03, 5'h0E, 5'h10, 5'h12};
        logic [31:0] vals [5] = '{32'h0, 32'h8000_0000, 32'h1, 32'hFFFF_FFFF, 32'h4000_0000};
        logic [31:0] w;
        foreach (masks[i])
            foreach (vals[j])
            begin
                w = {6'h00, masks[i], 5'h00, 16'hFFF8};
                issue(fctu_pkg::FCTU_OP_BR_CND, w, vals[j], 32'h0, j[0],
                    cnd(masks[i], vals[j]), 1'b0, sadr(w), 9'h000);
                issue(fctu_pkg::FCTU_OP_TRAP_CND, w, vals[j], 32'h0, 1'b0,
                    cnd(masks[i], vals[j]), 1'b1, tadr(w[8:0]), w[8:0]);
            end
        $display("test conditions done");
    endtask : t_cond
    // Long branches that wrap around the address space
    task automatic t_long();
        exec_ptr <= 32'h0000_0010;
        issue(fctu_pkg::FCTU_OP_JUMP_REL, 32'h03FF_FFF0, 32'h0, 32'h0, 1'b0, 1'b1, 1'b0,
            32'hFFFF_FFD0, 9'h000);
        exec_ptr <= 32'hFFFF_FFF0;
        issue(fctu_pkg::FCTU_OP_JUMP_REL, 32'h0000_0010, 32'h0, 32'h0, 1'b1, 1'b1, 1'b0,
            32'h0000_0030, 9'h000);
        $display("test long branch done");
    endtask : t_long
    // Status, mask, interrupt, disable, unmapped and target registers
    task automatic t_regs();
        irq_chk(1'b0);
        reg_write(4'h8, 32'h0000_0007);
        irq_chk(1'b1);
        reg_read(4'h4, 32'h0000_0007, "status");
        irq_chk(1'b0);
        reg_write(4'h8, 32'h0000_0001);
        issue(fctu_pkg::FCTU_OP_TRAP_SET, 32'h0000_0003, 32'h1, 32'h0, 1'b0, 1'b1, 1'b1,
            tadr(9'h003), 9'h003);
        irq_chk(1'b0);
        issue(fctu_pkg::FCTU_OP_JUMP_REG, 32'h0, 32'h0, 32'h0000_0100, 1'b0, 1'b1, 1'b0,
            32'h0000_0100, 9'h000);
        irq_chk(1'b1);
        reg_read(4'hC, 32'h0000_0100, "target");
        reg_read(4'h4, 32'h0000_0003, "status");
        reg_write(4'h0, 32'h0000_0000);
        issue(fctu_pkg::FCTU_OP_JUMP_REG, 32'h0, 32'h0, 32'h0000_0200, 1'b0, 1'b0, 1'b0,
            32'h0, 9'h000);
        reg_read(4'h4, 32'h0000_0000, "status");
        reg_write(4'h2, 32'hFFFF_FFFF);
        reg_read(4'h2, 32'h0000_0000, "unmapped");
        reg_read(4'h0, 32'h0000_0000, "ctrl");
        reg_write(4'h0, 32'h0000_0001);
        $display("test registers done");
    endtask : t_regs
    // Main sequence
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        ivalid = 1'b0;
        iop = fctu_pkg::FCTU_OP_NONE;
        idly = 1'b0;
        iword = 32'h0;
        src_a = 32'h0;
        src_b = 32'h0;
        exec_ptr = 32'h0000_1000;
        vec_base = 20'hABCDE;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_errors = 0;
        checked = 0;
        n_loads = 0;
        n_traps = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_jump_bound();
        t_bits();
        t_cond();
        t_long();
        t_regs();
        chk("load_count", n_loads, {16'h0, load_count});
        chk("trap_count", n_traps, {16'h0, trap_count});
        wrap_up();
    end
    // Watchdog against a hang
    initial
    begin
        #20000;
        n_errors++;
        wrap_up();
    end
endmodule : testbench
